/* File: atm_pkg.sv */
// Package for the advanced timer core: register map, field layout,
// reset values and the structs that carry the bus and configuration.
// Assumes a 32-bit APB master with 8-bit byte addresses.
package atm_pkg;

   localparam int NUM_CH = 4;
   localparam int NUM_REGS = 12;

   // Byte offsets of the register map.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_CH_MODE = 8'h18;
   localparam logic [7:0] ADDR_COUNT = 8'h24;
   localparam logic [7:0] ADDR_DIVIDER = 8'h28;
   localparam logic [7:0] ADDR_WRAP = 8'h2C;
   localparam logic [7:0] ADDR_REPEAT = 8'h30;
   localparam logic [7:0] ADDR_MATCH1 = 8'h34;
   localparam logic [7:0] ADDR_MATCH2 = 8'h38;
   localparam logic [7:0] ADDR_MATCH3 = 8'h3C;
   localparam logic [7:0] ADDR_MATCH4 = 8'h40;
   localparam logic [7:0] ADDR_GAP = 8'h44;

   // Reset values.
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [15:0] RST_DIVIDER = 16'h0000;
   localparam logic [15:0] RST_WRAP = 16'hFFFF;
   localparam logic [7:0] RST_REPEAT = 8'h00;
   localparam logic [15:0] RST_MATCH = 16'h0000;
   localparam logic [15:0] RST_GAP = 16'h0000;

   // Control and status fields.
   localparam int CTRL_ENABLE = 0;
   localparam int STATUS_UPDATE = 0;
   localparam int STATUS_CAP_LSB = 1;
   localparam int CH_MODE_INPUT_LSB = 0;
   localparam int CH_MODE_PRELOAD_LSB = 4;

   // Fault and gap register fields.
   localparam int GAP_DEAD_TIME_LSB = 0;
   localparam int GAP_LOCK_LSB = 8;
   localparam int GAP_IDLE_OFF = 10;
   localparam int GAP_RUN_OFF = 11;
   localparam int GAP_FAULT_EN = 12;
   localparam int GAP_FAULT_POL = 13;
   localparam int GAP_AUTO_OUT = 14;
   localparam logic [15:0] GAP_MASK = 16'h7FFF;
   localparam logic [15:0] GAP_LOCK_L1 = 16'h70FF;
   localparam logic [15:0] GAP_LOCK_L2 = 16'h7CFF;
   localparam logic [15:0] GAP_LOCK_FIELD = 16'h0300;

   typedef enum logic [1:0] {
      LOCK_OFF = 2'h0,
      LOCK_L1 = 2'h1,
      LOCK_L2 = 2'h2,
      LOCK_L3 = 2'h3
   } atm_lock_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } atm_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } atm_apb_rsp_t;

   typedef struct packed {
      logic auto_output_enable;
      logic fault_input_polarity;
      logic fault_input_enable;
      logic run_off_state_select;
      logic idle_off_state_select;
      atm_lock_t lock_level;
      logic [7:0] dead_time_setting;
   } atm_gap_cfg_t;

endpackage

/* File: atm_sync.sv */
// Two-flop synchroniser for the four capture input pins.
// Assumes the pins are asynchronous to i_core_clk.
`timescale 1ns/1ps
module atm_sync (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_pin,
   output logic [3:0] o_level
);

   typedef struct packed {
      logic [3:0] first;
      logic [3:0] second;
   } atm_sync_t;

   atm_sync_t st;
   atm_sync_t next_st;

   // The first stage feeds only the second, so metastability has a cycle
   // to settle before any edge detector sees it.
   always_comb begin
      next_st.first = i_pin;
      next_st.second = st.first;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_level = st.second;

endmodule // atm_sync

/* File: atm_divider.sv */
// Clock divider that turns the core clock into count clock ticks.
// Assumes the divider value and run level come from the same clock.
`timescale 1ns/1ps
module atm_divider (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_run,
   input wire logic [15:0] i_clock_divider,
   output logic o_tick
);

   typedef struct packed {
      logic [15:0] phase;
   } atm_div_t;

   atm_div_t st;
   atm_div_t next_st;

   // One tick every clock_divider + 1 core clocks.
   assign o_tick = i_run && (st.phase >= i_clock_divider);

   always_comb begin
      next_st = st;
      if (!i_run || o_tick) begin
         next_st.phase = 16'h0000;
      end else begin
         next_st.phase = st.phase + 16'h0001;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule // atm_divider

/* File: atm_timer.sv */
// Counting core and capture/compare store of a 16-bit control timer,
// with its APB register file.
// Assumes an APB master on i_core_clk and asynchronous capture pins.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps

// Behaviour
// - Counter advances once per clock_divider plus one core clocks.
// - A zero wrap limit holds the counter still.
// - Repeat count decrements per wrap; at zero emits update and reloads.
// - Input channels store the count latched by their latest capture edge, or a later match write.
// - Reading an output channel match register returns the active value.
// - Output channels compare their match value with the count continuously.
// - Without preload, a match write changes the compare at once.
// - With preload, a match write reaches the compare at the next update.
// - Lock level write-protects fault and gap fields; program them first.
module atm_timer (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire atm_pkg::atm_apb_req_t i_apb,
   output atm_pkg::atm_apb_rsp_t o_apb,
   input wire logic [3:0] i_chan_in,
   output logic [3:0] o_chan_out,
   output logic o_update_event,
   output atm_pkg::atm_gap_cfg_t o_gap_cfg
);

   typedef struct packed {
      logic enable;
      logic [15:0] count_value;
      logic [15:0] clock_divider;
      logic [15:0] wrap_limit;
      logic [7:0] repeat_value;
      logic [7:0] repeat_left;
      logic [3:0][15:0] match_buffer;
      logic [3:0][15:0] match_active;
      logic [3:0] ch_input;
      logic [3:0] ch_preload;
      logic [3:0] pin_prev;
      logic [3:0] chan_out;
      logic update;
      logic update_flag;
      logic [3:0] capture_flag;
      logic [15:0] gap;
      logic [31:0] rdata;
      logic slverr;
   } atm_state_t;

   atm_state_t st;
   atm_state_t next_st;

   logic [3:0] pin_level;
   logic tick;
   logic run;
   logic setup_phase;
   logic write_access;
   logic [atm_pkg::NUM_REGS-1:0] sel;
   logic [15:0] wdata16;
   logic [3:0] capture_edge;
   logic wrap_event;
   logic update_now;
   atm_pkg::atm_lock_t lock_level;

   // Maps a byte address onto a one-hot register select.
   function automatic logic [atm_pkg::NUM_REGS-1:0] reg_sel(
      input logic [7:0] addr
   );
      logic [atm_pkg::NUM_REGS-1:0] s;
      s = '0;
      case (addr)
         atm_pkg::ADDR_CTRL: s[0] = 1'b1;
         atm_pkg::ADDR_STATUS: s[1] = 1'b1;
         atm_pkg::ADDR_CH_MODE: s[2] = 1'b1;
         atm_pkg::ADDR_COUNT: s[3] = 1'b1;
         atm_pkg::ADDR_DIVIDER: s[4] = 1'b1;
         atm_pkg::ADDR_WRAP: s[5] = 1'b1;
         atm_pkg::ADDR_REPEAT: s[6] = 1'b1;
         atm_pkg::ADDR_MATCH1: s[7] = 1'b1;
         atm_pkg::ADDR_MATCH2: s[8] = 1'b1;
         atm_pkg::ADDR_MATCH3: s[9] = 1'b1;
         atm_pkg::ADDR_MATCH4: s[10] = 1'b1;
         atm_pkg::ADDR_GAP: s[11] = 1'b1;
         default: s = '0;
      endcase
      return s;
   endfunction

   // Bits of the fault and gap register that the lock level freezes.
   function automatic logic [15:0] gap_protect(
      input atm_pkg::atm_lock_t level
   );
      logic [15:0] m;
      m = 16'h0000;
      case (level)
         atm_pkg::LOCK_OFF: m = 16'h0000;
         atm_pkg::LOCK_L1: m = atm_pkg::GAP_LOCK_L1;
         atm_pkg::LOCK_L2: m = atm_pkg::GAP_LOCK_L2;
         atm_pkg::LOCK_L3: m = atm_pkg::GAP_LOCK_L2;
         default: m = atm_pkg::GAP_LOCK_L2;
      endcase
      return m;
   endfunction

   atm_sync u_sync (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_pin(i_chan_in),
      .o_level(pin_level)
   );

   atm_divider u_divider (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_run(run),
      .i_clock_divider(st.clock_divider),
      .o_tick(tick)
   );

   assign lock_level = atm_pkg::atm_lock_t'(
      st.gap[atm_pkg::GAP_LOCK_LSB +: 2]);
   assign run = st.enable && (st.wrap_limit != 16'h0000);
   assign setup_phase = i_apb.psel && !i_apb.penable;
   assign write_access = i_apb.psel && i_apb.penable && i_apb.pwrite &&
      !st.slverr;
   assign sel = reg_sel(i_apb.paddr);
   assign wdata16 = i_apb.pwdata[15:0];
   assign capture_edge = pin_level & ~st.pin_prev;
   assign wrap_event = tick && (st.count_value >= st.wrap_limit);
   assign update_now = wrap_event && (st.repeat_left == 8'h00);

   always_comb begin
      next_st = st;
      next_st.pin_prev = pin_level;
      next_st.update = update_now;

      // Counting core; a software write below overrides the count.
      if (tick) begin
         if (wrap_event) begin
            next_st.count_value = 16'h0000;
         end else begin
            next_st.count_value = st.count_value + 16'h0001;
         end
      end

      // The live repeat value is only sampled at a wrap that finds repeat_left at zero.
      if (wrap_event) begin
         if (update_now) begin
            next_st.repeat_left = st.repeat_value;
         end else begin
            next_st.repeat_left = st.repeat_left - 8'h01;
         end
      end

      // Software writes on the access phase edge.
      if (write_access) begin
         if (sel[0]) begin
            next_st.enable = i_apb.pwdata[atm_pkg::CTRL_ENABLE];
         end
         if (sel[2] && (lock_level != atm_pkg::LOCK_L3)) begin
            next_st.ch_input =
               i_apb.pwdata[atm_pkg::CH_MODE_INPUT_LSB +: 4];
            next_st.ch_preload =
               i_apb.pwdata[atm_pkg::CH_MODE_PRELOAD_LSB +: 4];
         end
         if (sel[3]) begin
            next_st.count_value = wdata16;
         end
         if (sel[4]) begin
            next_st.clock_divider = wdata16;
         end
         if (sel[5]) begin
            next_st.wrap_limit = wdata16;
         end
         if (sel[6]) begin
            next_st.repeat_value = i_apb.pwdata[7:0];
         end
         if (sel[11]) begin
            // The lock field itself is written once, while still open.
            next_st.gap = ((st.gap & gap_protect(lock_level)) |
               (wdata16 & ~gap_protect(lock_level))) &
               atm_pkg::GAP_MASK;
            if (lock_level != atm_pkg::LOCK_OFF) begin
               next_st.gap[atm_pkg::GAP_LOCK_LSB +: 2] =
                  st.gap[atm_pkg::GAP_LOCK_LSB +: 2];
            end
         end
      end

      // Per-channel capture and compare.
      for (int i = 0; i < atm_pkg::NUM_CH; i++) begin
         if (write_access && sel[7 + i]) begin
            next_st.match_buffer[i] = wdata16;
            if (!st.ch_preload[i] || st.ch_input[i]) begin
               next_st.match_active[i] = wdata16;
            end
         end
         if (st.ch_input[i]) begin
            // A capture edge outranks a software write in the same cycle.
            if (capture_edge[i]) begin
               next_st.match_active[i] = st.count_value;
            end
            next_st.chan_out[i] = 1'b0;
         end else begin
            if (update_now && st.ch_preload[i]) begin
               next_st.match_active[i] = st.match_buffer[i];
            end
            next_st.chan_out[i] =
               (st.count_value < st.match_active[i]);
         end
      end

      // Sticky status; a new event wins over a clear in the same cycle.
      if (write_access && sel[1]) begin
         if (i_apb.pwdata[atm_pkg::STATUS_UPDATE]) begin
            next_st.update_flag = 1'b0;
         end
         next_st.capture_flag = st.capture_flag &
            ~i_apb.pwdata[atm_pkg::STATUS_CAP_LSB +: 4];
      end
      if (update_now) begin
         next_st.update_flag = 1'b1;
      end
      next_st.capture_flag = next_st.capture_flag |
         (capture_edge & st.ch_input);

      // Read data and error are prepared in the setup phase so that
      // both come from flops while pready stays high.
      if (setup_phase) begin
         next_st.slverr = (sel == '0);
         next_st.rdata = 32'h0000_0000;
         case (1'b1)
            sel[0]: next_st.rdata[atm_pkg::CTRL_ENABLE] = st.enable;
            sel[1]: begin
               next_st.rdata[atm_pkg::STATUS_UPDATE] = st.update_flag;
               next_st.rdata[atm_pkg::STATUS_CAP_LSB +: 4] =
                  st.capture_flag;
            end
            sel[2]: begin
               next_st.rdata[atm_pkg::CH_MODE_INPUT_LSB +: 4] =
                  st.ch_input;
               next_st.rdata[atm_pkg::CH_MODE_PRELOAD_LSB +: 4] =
                  st.ch_preload;
            end
            sel[3]: next_st.rdata[15:0] = st.count_value;
            sel[4]: next_st.rdata[15:0] = st.clock_divider;
            sel[5]: next_st.rdata[15:0] = st.wrap_limit;
            sel[6]: next_st.rdata[7:0] = st.repeat_value;
            sel[7]: next_st.rdata[15:0] = st.match_active[0];
            sel[8]: next_st.rdata[15:0] = st.match_active[1];
            sel[9]: next_st.rdata[15:0] = st.match_active[2];
            sel[10]: next_st.rdata[15:0] = st.match_active[3];
            sel[11]: next_st.rdata[15:0] = st.gap;
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         st <= '0;
         st.count_value <= atm_pkg::RST_COUNT;
         st.clock_divider <= atm_pkg::RST_DIVIDER;
         st.wrap_limit <= atm_pkg::RST_WRAP;
         st.repeat_value <= atm_pkg::RST_REPEAT;
         st.repeat_left <= atm_pkg::RST_REPEAT;
         st.match_buffer <= {atm_pkg::NUM_CH{atm_pkg::RST_MATCH}};
         st.match_active <= {atm_pkg::NUM_CH{atm_pkg::RST_MATCH}};
         st.gap <= atm_pkg::RST_GAP;
      end else begin
         st <= next_st;
      end
   end

   // Zero wait states: every access completes in its first access cycle.
   assign o_apb.pready = 1'b1;
   assign o_apb.prdata = st.rdata;
   assign o_apb.pslverr = i_apb.psel && i_apb.penable && st.slverr;

   assign o_chan_out = st.chan_out;
   assign o_update_event = st.update;

   assign o_gap_cfg.dead_time_setting =
      st.gap[atm_pkg::GAP_DEAD_TIME_LSB +: 8];
   assign o_gap_cfg.lock_level = lock_level;
   assign o_gap_cfg.idle_off_state_select = st.gap[atm_pkg::GAP_IDLE_OFF];
   assign o_gap_cfg.run_off_state_select = st.gap[atm_pkg::GAP_RUN_OFF];
   assign o_gap_cfg.fault_input_enable = st.gap[atm_pkg::GAP_FAULT_EN];
   assign o_gap_cfg.fault_input_polarity = st.gap[atm_pkg::GAP_FAULT_POL];
   assign o_gap_cfg.auto_output_enable = st.gap[atm_pkg::GAP_AUTO_OUT];

endmodule // atm_timer

/* File: atm_timer_checker.sv */
// Port-level assertions for the timer core.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module atm_timer_checker (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire atm_pkg::atm_apb_req_t i_apb,
   input wire atm_pkg::atm_apb_rsp_t o_apb,
   input wire logic [3:0] i_chan_in,
   input wire logic [3:0] o_chan_out,
   input wire logic o_update_event,
   input wire atm_pkg::atm_gap_cfg_t o_gap_cfg
);
   logic wr;
   logic lk;
   logic run;
   logic wrap_zero;
   logic [3:0] in_mode;
   logic [3:0] pre;
   logic [2:0] age;
   assign wr = i_apb.psel && i_apb.penable && i_apb.pwrite;
   assign lk = o_gap_cfg.lock_level != atm_pkg::LOCK_OFF;
   // Shadows of a few registers, so outputs can be tied to their cause.
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         run <= 1'b0;
         wrap_zero <= 1'b0;
         in_mode <= 4'h0;
         pre <= 4'h0;
         age <= 3'h0;
      end else begin
         age <= wr ? 3'h0 : age + {2'h0, age != 3'h7};
         if (wr && i_apb.paddr == atm_pkg::ADDR_CTRL)
            run <= i_apb.pwdata[0];
         if (wr && i_apb.paddr == atm_pkg::ADDR_WRAP)
            wrap_zero <= i_apb.pwdata[15:0] == 16'h0000;
         if (wr && i_apb.paddr == atm_pkg::ADDR_CH_MODE &&
               o_gap_cfg.lock_level != atm_pkg::LOCK_L3) begin
            in_mode <= i_apb.pwdata[3:0];
            pre <= i_apb.pwdata[7:4];
         end
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   chk_update_single:
      assert property (o_update_event |=> !o_update_event)
      else $error("update pulse too long");
   chk_stop_quiet:
      assert property (wrap_zero [*4] |-> !o_update_event)
      else $error("update while wrap limit is zero");
   chk_gap_write:
      assert property (wr && i_apb.paddr == atm_pkg::ADDR_GAP && !lk
         |=> o_gap_cfg.dead_time_setting == $past(i_apb.pwdata[7:0]))
      else $error("dead time not written");
   chk_lock_gap:
      assert property (lk |=> $stable(o_gap_cfg.dead_time_setting)
         && $stable(o_gap_cfg.auto_output_enable))
      else $error("locked field changed");
   chk_lock_off_state:
      assert property (o_gap_cfg.lock_level[1] |=>
         $stable({o_gap_cfg.idle_off_state_select,
         o_gap_cfg.run_off_state_select}))
      else $error("locked off-state changed");
   chk_lock_hold:
      assert property (lk |=> $stable(o_gap_cfg.lock_level))
      else $error("lock level changed");
   chk_input_low:
      assert property (age > 3'h2 |-> (o_chan_out & in_mode) == 4'h0)
      else $error("input channel drives output");
   chk_match_now:
      assert property (wr && i_apb.paddr == atm_pkg::ADDR_MATCH1 &&
         i_apb.pwdata[15:0] == 16'h0000 && !pre[0] && !in_mode[0]
         |-> ##[1:3] !o_chan_out[0])
      else $error("match write not applied");
   chk_match_held:
      assert property (wr && i_apb.paddr == atm_pkg::ADDR_MATCH1 && pre[0]
         && !in_mode[0] && !run && age > 3'h3
         |=> $stable(o_chan_out[0]) [*3])
      else $error("preloaded match applied early");
endmodule // atm_timer_checker
bind atm_timer atm_timer_checker i_atm_timer_checker (
   .i_core_clk(i_core_clk),
   .i_rst_n(i_rst_n),
   .i_apb(i_apb),
   .o_apb(o_apb),
   .i_chan_in(i_chan_in),
   .o_chan_out(o_chan_out),
   .o_update_event(o_update_event),
   .o_gap_cfg(o_gap_cfg)
);

/* File: tb_top.sv */
// Bench for the timer core: APB master, capture pins, update monitor.
// Assumes atm_pkg and the bound checker are compiled before it.
`timescale 1ns/1ps
`define CHK(a, b) \
   begin \
      compares++; \
      if ((a) !== (b)) begin \
         n_mismatch++; \
         $display("wrong value at %0t: %h %h", $time, (a), (b)); \
      end \
   end
module tb_top;
   logic i_core_clk = 1'b0;
   logic i_rst_n = 1'b0;
   atm_pkg::atm_apb_req_t i_apb = '0;
   atm_pkg::atm_apb_rsp_t o_apb;
   logic [3:0] i_chan_in = 4'h0;
   logic [3:0] o_chan_out;
   logic o_update_event;
   atm_pkg::atm_gap_cfg_t o_gap_cfg;
   int n_mismatch = 0;
   int compares = 0;
   int cyc = 0;
   int upd[$];
   logic [31:0] q;
   logic e;
   logic [7:0] a;
   logic [15:0] v;
   logic [15:0] m;
   int r1;
   int r2;
   atm_timer i_atm_timer (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_apb(i_apb),
      .o_apb(o_apb),
      .i_chan_in(i_chan_in),
      .o_chan_out(o_chan_out),
      .o_update_event(o_update_event),
      .o_gap_cfg(o_gap_cfg)
   );
   always #25 i_core_clk = ~i_core_clk;
   // Cycle stamps of update pulses; the cycle limit cuts a hang short.
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (o_update_event === 1'b1)
         upd.push_back(cyc);
      if (cyc == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   function automatic int per_upd(int r);
      return (r + 1) * 3;
   endfunction
   function automatic logic [15:0] gap_exp(logic [15:0] o, logic [15:0] w);
      logic [15:0] k;
      k = atm_pkg::GAP_LOCK_L2 | atm_pkg::GAP_LOCK_FIELD;
      return (o & k) | (w & atm_pkg::GAP_MASK & ~k);
   endfunction
   task automatic apb(input logic w, input logic [7:0] ad,
         input logic [31:0] d);
      @(posedge i_core_clk);
      i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: d};
      @(posedge i_core_clk);
      i_apb.penable <= 1'b1;
      @(posedge i_core_clk);
      while (o_apb.pready !== 1'b1)
         @(posedge i_core_clk);
      q = o_apb.prdata;
      e = o_apb.pslverr;
      i_apb.psel <= 1'b0;
      i_apb.penable <= 1'b0;
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(98));
      repeat (5) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      for (int k = 0; k < 9; k++) begin
         a = atm_pkg::ADDR_COUNT + 8'(4 * k);
         m = (k == 2) ? atm_pkg::RST_WRAP : 16'h0000;
         apb(1'b0, a, 32'h0);
         `CHK(q, {16'h0, m})
         if (k < 8) begin
            v = 16'($urandom);
            apb(1'b1, a, {16'($urandom), v});
            apb(1'b0, a, 32'h0);
            m = (k == 3) ? 16'h00FF : 16'hFFFF;
            `CHK(q, {16'h0, v & m})
         end
      end
      apb(1'b0, 8'h04, 32'h0);
      `CHK({e, q}, 33'h1_0000_0000)
      $display("registers done");
      for (int d = 0; d < 4; d++) begin
         apb(1'b1, atm_pkg::ADDR_DIVIDER, d);
         apb(1'b1, atm_pkg::ADDR_WRAP, 32'hFFFF);
         apb(1'b1, atm_pkg::ADDR_COUNT, 32'h0);
         apb(1'b1, atm_pkg::ADDR_CTRL, 32'h1);
         repeat (40) @(posedge i_core_clk);
         apb(1'b1, atm_pkg::ADDR_CTRL, 32'h0);
         apb(1'b0, atm_pkg::ADDR_COUNT, 32'h0);
         // Enable to disable spans 43 edges; the divider phase adds one.
         v = q[15:0] + 16'h1 - 16'(43 / (d + 1));
         `CHK(v <= 16'h2, 1'b1)
      end
      v = 16'($urandom);
      apb(1'b1, atm_pkg::ADDR_WRAP, 32'h0);
      apb(1'b1, atm_pkg::ADDR_COUNT, {16'h0, v});
      r1 = upd.size();
      apb(1'b1, atm_pkg::ADDR_CTRL, 32'h1);
      repeat (20) @(posedge i_core_clk);
      apb(1'b0, atm_pkg::ADDR_COUNT, 32'h0);
      `CHK(q[15:0], v)
      `CHK(upd.size(), r1)
      $display("divider and hold done");
      apb(1'b1, atm_pkg::ADDR_CTRL, 32'h0);
      r1 = 1 + $urandom % 3;
      r2 = r1 % 3 + 1;
      apb(1'b1, atm_pkg::ADDR_DIVIDER, 32'h0);
      apb(1'b1, atm_pkg::ADDR_WRAP, 32'h2);
      apb(1'b1, atm_pkg::ADDR_REPEAT, r1);
      apb(1'b1, atm_pkg::ADDR_COUNT, 32'h0);
      upd.delete();
      apb(1'b1, atm_pkg::ADDR_CTRL, 32'h1);
      while (upd.size() < 2)
         @(negedge i_core_clk);
      apb(1'b1, atm_pkg::ADDR_REPEAT, r2);
      while (upd.size() < 4)
         @(negedge i_core_clk);
      apb(1'b1, atm_pkg::ADDR_CTRL, 32'h0);
      `CHK(upd[1] - upd[0], per_upd(r1))
      `CHK(upd[2] - upd[1], per_upd(r1))
      `CHK(upd[3] - upd[2], per_upd(r2))
      $display("repeat done");
      apb(1'b1, atm_pkg::ADDR_MATCH1, 32'h0);
      v = 16'($urandom % 65534);
      apb(1'b1, atm_pkg::ADDR_COUNT, {16'h0, v});
      for (int k = 0; k < 4; k++) begin
         a = atm_pkg::ADDR_MATCH1 + 8'(4 * k);
         apb(1'b1, a, {16'h0, v + 16'h1});
         repeat (3) @(negedge i_core_clk);
         `CHK(o_chan_out[k], 1'b1)
         apb(1'b1, a, {16'h0, v});
         repeat (3) @(negedge i_core_clk);
         `CHK(o_chan_out[k], 1'b0)
      end
      apb(1'b1, atm_pkg::ADDR_CH_MODE, 32'h10);
      repeat (6) @(posedge i_core_clk);
      apb(1'b1, atm_pkg::ADDR_MATCH1, 32'hFFFF);
      repeat (3) @(negedge i_core_clk);
      `CHK(o_chan_out[0], 1'b0)
      apb(1'b0, atm_pkg::ADDR_MATCH1, 32'h0);
      `CHK(q[15:0], v)
      apb(1'b1, atm_pkg::ADDR_WRAP, 32'h3);
      apb(1'b1, atm_pkg::ADDR_COUNT, 32'h0);
      upd.delete();
      apb(1'b1, atm_pkg::ADDR_CTRL, 32'h1);
      while (upd.size() < 1)
         @(negedge i_core_clk);
      apb(1'b1, atm_pkg::ADDR_CTRL, 32'h0);
      apb(1'b0, atm_pkg::ADDR_MATCH1, 32'h0);
      `CHK(q[15:0], 16'hFFFF)
      `CHK(o_chan_out[0], 1'b1)
      $display("compare done");
      apb(1'b1, atm_pkg::ADDR_CH_MODE, 32'h0F);
      for (int k = 0; k < 8; k++) begin
         v = 16'($urandom);
         apb(1'b1, atm_pkg::ADDR_COUNT, {16'h0, v});
         i_chan_in[k / 2] <= 1'b1;
         repeat (4) @(posedge i_core_clk);
         i_chan_in[k / 2] <= 1'b0;
         repeat (2) @(posedge i_core_clk);
         apb(1'b0, atm_pkg::ADDR_MATCH1 + 8'(4 * (k / 2)), 32'h0);
         `CHK(q[15:0], v)
         `CHK(o_chan_out[k / 2], 1'b0)
      end
      // Both kinds of event have happened by now; write one clears them.
      apb(1'b0, atm_pkg::ADDR_STATUS, 32'h0);
      `CHK(q, 32'h0000_001F)
      apb(1'b1, atm_pkg::ADDR_STATUS, 32'h0000_001F);
      apb(1'b0, atm_pkg::ADDR_STATUS, 32'h0);
      `CHK(q, 32'h0000_0000)
      $display("capture done");
      // Every protected field goes in with the first write.
      v = (16'($urandom) & 16'h7CFF) | 16'h0200;
      apb(1'b1, atm_pkg::ADDR_GAP, {16'h0, v});
      @(negedge i_core_clk);
      `CHK({1'b0, o_gap_cfg}, v)
      m = 16'($urandom);
      apb(1'b1, atm_pkg::ADDR_GAP, {16'h0, m});
      apb(1'b0, atm_pkg::ADDR_GAP, 32'h0);
      `CHK(q[15:0], gap_exp(v, m))
      `CHK({1'b0, o_gap_cfg}, gap_exp(v, m))
      $display("lock done");
      end_of_test();
   end
endmodule // tb_top
